// ===== rtl/fsq_core.sv
// Flash programming sequencer: serial commands, erase and program timing
`include "fsq_defines.svh"
module fsq_core
    import fsq_pkg::*;
#(
    parameter int MAIN_AW    = 15,
    parameter int INFO_AW    = 9,
    parameter int PAGE_AW    = 9,
    parameter int ERASE_CYC  = `FSQ_ERASE_CYC,
    parameter int BYTE_CYC   = `FSQ_BYTE_CYC
)
(
    // Crystal clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // Programming control
    input  wire logic       PROGRAMMING_MODE_PIN,
    // Serial port
    input  wire logic       SERIAL_SELECT_LOW,
    input  wire logic       SERIAL_CLOCK,
    input  wire logic       SERIAL_IN,
    output logic            SERIAL_OUT,
    // Status
    output logic            NOT_READY,
    output logic            WRITE_ENABLED,
    output logic            INFO_AREA_SELECT,
    output logic            MAIN_READBACK_BLOCK,
    output logic            INFO_READBACK_BLOCK,
    output logic            DATA_MEMORY_ENABLE,
    output logic [7:0]      PROTECTED_PAGE
);
    localparam int MAIN_BYTES = 1 << MAIN_AW;
    localparam int INFO_BYTES = 1 << INFO_AW;
    localparam int PAGE_BYTES = 1 << PAGE_AW;
    localparam int ERASE_LOAD = ERASE_CYC - `FSQ_SYNC_LAT;

    fsq_core_s q;
    fsq_core_s d;
    fsq_rx_s   rx;

    logic [7:0] main_mem [MAIN_BYTES];
    logic [7:0] info_mem [INFO_BYTES];
    logic [7:0] page_buf [256];

    logic               mwe;
    logic               iwe;
    logic               bwe;
    logic [MAIN_AW-1:0] maddr;
    logic [INFO_AW-1:0] iaddr;
    logic [7:0]         bidx;
    logic [7:0]         wdat;
    logic [7:0]         bdat;
    logic               busy;
    logic               programming_mode_pin_on;
    logic               cs_act;
    logic               cs_end;
    logic               byte_ev;
    logic               main_rb;
    logic               info_rb;
    logic [19:0]        elap_q;

    // Busy time of a program of n bytes, less the select sync delay
    function automatic logic [19:0] programming_mode_pin_load(input logic [8:0] n);
        programming_mode_pin_load = 20'((int'(n) + 1) * BYTE_CYC - `FSQ_SYNC_LAT);
    endfunction : programming_mode_pin_load

    // Read one byte for the serial port, masked when blocked
    function automatic logic [7:0] rd_byte(input logic [15:0] p);
        if (q.info_sel)
            rd_byte = info_rb ? 8'h00 : info_mem[p[INFO_AW-1:0]];
        else
            rd_byte = main_rb ? 8'h00 : main_mem[p[MAIN_AW-1:0]];
    endfunction : rd_byte

    // Serial clock domain front end
    fsq_link u_link (
        .sck        (SERIAL_CLOCK),
        .rst        (RST),
        .select_low (SERIAL_SELECT_LOW),
        .mosi       (SERIAL_IN),
        .miso       (SERIAL_OUT),
        .tx_byte    (q.tx),
        .rx         (rx)
    );

    // Synchronised views of pins and the byte toggle
    assign programming_mode_pin_on = q.programming_mode_pin_s[1];
    assign cs_act  = q.cs_s[1];
    assign cs_end  = ~q.cs_s[1] & q.cs_s[2];
    assign byte_ev = q.tg_s[1] ^ q.tg_s[2];
    assign busy    = (q.mode == FSQ_BUSY);
    assign main_rb = info_mem[`FSQ_INFO_RBM] != `FSQ_ERASED;
    assign info_rb = info_mem[`FSQ_INFO_RBI] != `FSQ_ERASED;

    // Next-state logic
    always_comb
    begin
        logic [7:0]  cmd_now;
        logic [15:0] ptr;
        logic [8:0]  n;
        d = q;
        cmd_now = q.cmd;
        ptr = q.rptr;
        n = 9'h000;
        mwe = 1'b0;
        iwe = 1'b0;
        bwe = 1'b0;
        maddr = (q.addr[MAIN_AW-1:0] + q.walk[MAIN_AW-1:0]);
        iaddr = (q.addr[INFO_AW-1:0] + q.walk[INFO_AW-1:0]);
        bidx = q.bc[7:0] - 8'h03;
        bdat = rx.data;
        wdat = `FSQ_ERASED;
        // Two-stage synchronisers; stage 2 feeds the edge detectors
        d.programming_mode_pin_s = {q.programming_mode_pin_s[0], PROGRAMMING_MODE_PIN};
        d.cs_s = {q.cs_s[1:0], ~SERIAL_SELECT_LOW};
        d.tg_s = {q.tg_s[1:0], rx.tgl};
        // Byte collection within a frame
        if (byte_ev && cs_act)
        begin
            if (q.bc == 9'h000)
                cmd_now = rx.data;
            d.cmd = cmd_now;
            if (q.bc == 9'h001)
                d.addr[15:8] = rx.data;
            if (q.bc == 9'h002)
                d.addr[7:0] = rx.data;
            if (q.bc != `FSQ_BC_MAX)
                d.bc = q.bc + 9'h001;
            d.tx = 8'h00;
            if (cmd_now == `FSQ_CMD_STAT_RD)
                d.tx = q.stat;
            else if (cmd_now == `FSQ_CMD_READ && !busy
                     && q.bc >= 9'h002)
            begin
                if (q.bc == 9'h002)
                    ptr = {q.addr[15:8], rx.data};
                d.tx = rd_byte(ptr);
                d.rptr = ptr + 16'h0001;
            end
            if (cmd_now == `FSQ_CMD_PROGRAMMING_MODE_PIN && !busy
                && q.bc >= `FSQ_HDR_BYTES
                && q.bc < `FSQ_HDR_BYTES + `FSQ_PAGE_MAX)
                bwe = 1'b1;
        end
        if (!cs_act)
            d.bc = 9'h000;
        if (busy)
        begin
            // Walk the target bytes, one per cycle
            if (q.walk < q.lim)
            begin
                d.walk = q.walk + 16'h0001;
                case (q.op)
                    FSQ_OP_ERALL:
                    begin
                        mwe = 1'b1;
                    end
                    FSQ_OP_ERPG:
                    begin
                        mwe = ~q.info_sel;
                        iwe = q.info_sel;
                    end
                    FSQ_OP_PROGRAMMING_MODE_PIN:
                    begin
                        // Programming only clears bits
                        mwe = ~q.info_sel;
                        iwe = q.info_sel;
                        wdat = page_buf[q.walk[7:0]] & (q.info_sel
                            ? info_mem[iaddr] : main_mem[maddr]);
                    end
                    FSQ_OP_RBMAIN, FSQ_OP_RBINFO:
                    begin
                        iwe = 1'b1;
                        wdat = `FSQ_RB_MARK;
                    end
                    default:
                    begin
                        mwe = 1'b0;
                    end
                endcase
            end
            // Completion drops not-ready and write enable
            if (q.timer == 20'h00000)
            begin
                d.mode = FSQ_IDLE;
                d.op = FSQ_OP_NONE;
                d.wen = 1'b0;
            end
            else
                d.timer = q.timer - 20'h00001;
        end
        else if (cs_end && programming_mode_pin_on)
        begin
            // Operations start only when the frame ends
            d.walk = 16'h0000;
            case (q.cmd)
                `FSQ_CMD_WEN_SET:
                begin
                    d.wen = 1'b1;
                end
                `FSQ_CMD_STAT_WR:
                begin
                    if (q.bc >= 9'h002)
                    begin
                        d.wen = q.addr[8 + `FSQ_SR_WEN];
                        d.info_sel = q.addr[8 + `FSQ_SR_INFO];
                    end
                end
                `FSQ_CMD_ERALL:
                begin
                    if (q.wen)
                    begin
                        d.mode = FSQ_BUSY;
                        d.op = FSQ_OP_ERALL;
                        d.erased = 1'b1;
                        d.addr = 16'h0000;
                        d.lim = 16'(MAIN_BYTES);
                        d.timer = 20'(ERASE_LOAD);
                    end
                end
                `FSQ_CMD_ERPG:
                begin
                    // Protected main array blocks page erase, except info erase after bulk erase
                    if (q.wen && q.bc >= 9'h002 && (!main_rb
                        || (q.info_sel && q.erased)))
                    begin
                        d.mode = FSQ_BUSY;
                        d.op = FSQ_OP_ERPG;
                        d.addr = q.info_sel ? 16'h0000
                            : 16'(q.addr[15:8] * PAGE_BYTES);
                        d.lim = q.info_sel ? 16'(INFO_BYTES)
                            : 16'(PAGE_BYTES);
                        d.timer = 20'(ERASE_LOAD);
                    end
                end
                `FSQ_CMD_PROGRAMMING_MODE_PIN:
                begin
                    if (q.wen && !main_rb && q.bc > `FSQ_HDR_BYTES)
                    begin
                        n = q.bc - `FSQ_HDR_BYTES;
                        if (n > `FSQ_PAGE_MAX)
                            n = `FSQ_PAGE_MAX;
                        d.mode = FSQ_BUSY;
                        d.op = FSQ_OP_PROGRAMMING_MODE_PIN;
                        d.nb = n;
                        d.lim = {7'h00, n};
                        d.timer = programming_mode_pin_load(n);
                    end
                end
                `FSQ_CMD_RBMAIN, `FSQ_CMD_RBINFO:
                begin
                    if (q.wen)
                    begin
                        d.mode = FSQ_BUSY;
                        d.op = (q.cmd == `FSQ_CMD_RBMAIN)
                            ? FSQ_OP_RBMAIN : FSQ_OP_RBINFO;
                        d.addr = (q.cmd == `FSQ_CMD_RBMAIN)
                            ? 16'(`FSQ_INFO_RBM) : 16'(`FSQ_INFO_RBI);
                        d.nb = 9'h001;
                        d.lim = 16'h0001;
                        d.timer = 20'(BYTE_CYC - `FSQ_SYNC_LAT);
                    end
                end
                default:
                begin
                    d.walk = 16'h0000;
                end
            endcase
        end
        // Registered status views
        d.stat = 8'h00;
        d.stat[`FSQ_SR_NRDY] = (d.mode == FSQ_BUSY);
        d.stat[`FSQ_SR_WEN] = d.wen;
        d.stat[`FSQ_SR_INFO] = d.info_sel;
        d.stat[`FSQ_SR_RBI] = info_rb;
        d.stat[`FSQ_SR_RBM] = main_rb;
        d.prot = info_mem[`FSQ_INFO_PROT];
        d.dmem = info_mem[`FSQ_INFO_DMEM] != `FSQ_ERASED;
    end

    // State register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            q <= '0;
        else
            q <= d;
    end

    // Flash arrays and page buffer
    always_ff @(posedge CLK)
    begin
        if (mwe)
            main_mem[maddr] <= wdat;
        if (iwe)
            info_mem[iaddr] <= wdat;
        if (bwe)
            page_buf[bidx] <= bdat;
    end

    // Busy cycle count for the checks below
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            elap_q <= 20'h00000;
        else if (!busy)
            elap_q <= 20'h00000;
        else
            elap_q <= elap_q + 20'h00001;
    end

    // Outputs
    assign NOT_READY = q.stat[`FSQ_SR_NRDY];
    assign WRITE_ENABLED = q.stat[`FSQ_SR_WEN];
    assign INFO_AREA_SELECT = q.stat[`FSQ_SR_INFO];
    assign MAIN_READBACK_BLOCK = q.stat[`FSQ_SR_RBM];
    assign INFO_READBACK_BLOCK = q.stat[`FSQ_SR_RBI];
    assign DATA_MEMORY_ENABLE = q.dmem;
    assign PROTECTED_PAGE = q.prot;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_erase_all_time: assert property (busy && q.timer == 20'h0
        && q.op == FSQ_OP_ERALL |-> elap_q == 20'(ERASE_LOAD))
        else $error("bulk erase length wrong");
    a_page_erase_time: assert property (busy && q.timer == 20'h0
        && q.op == FSQ_OP_ERPG |-> elap_q == 20'(ERASE_LOAD))
        else $error("page erase length wrong");
    a_programming_mode_pin_time: assert property (busy && q.timer == 20'h0
        && q.op == FSQ_OP_PROGRAMMING_MODE_PIN |-> elap_q == programming_mode_pin_load(q.nb))
        else $error("program length wrong");
    a_block_time: assert property (busy && q.timer == 20'h0
        && (q.op == FSQ_OP_RBMAIN || q.op == FSQ_OP_RBINFO)
        |-> elap_q == 20'(BYTE_CYC - `FSQ_SYNC_LAT))
        else $error("readback block length wrong");
    a_busy_ignores: assert property (busy && q.timer != 20'h0
        && cs_end |=> $stable(q.op) && $stable(q.wen)
        && $stable(q.info_sel))
        else $error("command accepted while busy");
    a_block_wen_clear: assert property (busy && q.timer == 20'h0
        && q.op == FSQ_OP_RBMAIN |=> !WRITE_ENABLED ##1 !q.wen)
        else $error("write enable kept after block");
    a_info_untouched: assert property (q.op == FSQ_OP_ERALL
        |-> !iwe)
        else $error("bulk erase touched info area");
    a_info_refuse: assert property (!busy && cs_end && programming_mode_pin_on
        && q.cmd == `FSQ_CMD_ERPG && q.info_sel && main_rb
        && !q.erased |=> !busy [*2])
        else $error("info erase accepted while protected");
    a_status_busy: assert property ($rose(busy) |-> NOT_READY
        throughout (busy [*3]))
        else $error("not-ready low during operation");
    a_start_on_cs: assert property ($rose(busy) |-> $past(cs_end)
        && !cs_act)
        else $error("operation started inside frame");
    a_info_route: assert property (busy && q.op == FSQ_OP_PROGRAMMING_MODE_PIN
        && q.info_sel && q.walk < q.lim |-> iwe && !mwe)
        else $error("info program went to main array");

    c_erase_done: cover property (busy && q.op == FSQ_OP_ERALL
        ##1 !busy);
    c_programming_mode_pin_done: cover property (busy && q.op == FSQ_OP_PROGRAMMING_MODE_PIN ##1 !busy);
    c_status_read: cover property (byte_ev
        && q.cmd == `FSQ_CMD_STAT_RD && busy);
    c_info_erase: cover property ($rose(busy) && q.op == FSQ_OP_ERPG
        && q.info_sel);
endmodule : fsq_core

// ===== common/fsq_defines.svh
// Constants for the flash programming sequencer
// What this block does
// - Bulk erase lasts 360000 cycles after select
// - N-byte program ends (N+1)*365 cycles later
// - Info select bit routes programs to info area
// - Data memory enable byte at info 0x0021
// - Main readback block programs in 365 cycles
// - Info readback block programs in 365 cycles
// - Page erase ends 360000 cycles after select
// - Info erase refused while main protected, unerased
// - Not-ready bit high while erase or program runs
// - Bulk erase leaves info area untouched
// - While busy only status read is served
// - Main readback block clears write enable
`ifndef FSQ_DEFINES_SVH
`define FSQ_DEFINES_SVH
// Serial command codes
`define FSQ_CMD_WEN_SET 8'h06
`define FSQ_CMD_STAT_WR 8'h01
`define FSQ_CMD_STAT_RD 8'h05
`define FSQ_CMD_READ   8'h03
`define FSQ_CMD_PROGRAMMING_MODE_PIN   8'h02
`define FSQ_CMD_ERPG   8'h52
`define FSQ_CMD_ERALL  8'h62
`define FSQ_CMD_RBMAIN 8'h85
`define FSQ_CMD_RBINFO 8'h84
// Status byte bit positions
`define FSQ_SR_NRDY 0
`define FSQ_SR_WEN  1
`define FSQ_SR_INFO 3
`define FSQ_SR_RBI  5
`define FSQ_SR_RBM  6
// Info area byte addresses
`define FSQ_INFO_PROT 9'h020
`define FSQ_INFO_DMEM 9'h021
`define FSQ_INFO_RBI  9'h022
`define FSQ_INFO_RBM  9'h023
// Byte values
`define FSQ_ERASED  8'hff
`define FSQ_RB_MARK 8'h00
// Timing in crystal cycles
`define FSQ_ERASE_CYC 360000
`define FSQ_BYTE_CYC  365
`define FSQ_SYNC_LAT  4
// Frame layout
`define FSQ_HDR_BYTES 9'h003
`define FSQ_PAGE_MAX  9'h100
`define FSQ_BC_MAX    9'h1ff
`endif

// ===== common/fsq_pkg.sv
// Types shared by the flash programming sequencer
package fsq_pkg;
    typedef enum logic [2:0] {
        FSQ_OP_NONE   = 3'b000,
        FSQ_OP_ERALL  = 3'b001,
        FSQ_OP_ERPG   = 3'b010,
        FSQ_OP_PROGRAMMING_MODE_PIN   = 3'b011,
        FSQ_OP_RBMAIN = 3'b100,
        FSQ_OP_RBINFO = 3'b101
    } fsq_op_e;

    typedef enum logic {
        FSQ_IDLE = 1'b0,
        FSQ_BUSY = 1'b1
    } fsq_mode_e;

    // Received byte crossing out of the serial clock domain
    typedef struct packed {
        logic       tgl;
        logic [7:0] data;
    } fsq_rx_s;

    // Serial-side shift state
    typedef struct packed {
        logic [2:0] bitcnt;
        logic [6:0] sr;
    } fsq_link_s;

    // Core state on the crystal clock
    typedef struct packed {
        logic [1:0]  programming_mode_pin_s;
        logic [2:0]  cs_s;
        logic [2:0]  tg_s;
        fsq_mode_e   mode;
        fsq_op_e     op;
        logic [7:0]  cmd;
        logic [8:0]  bc;
        logic [15:0] addr;
        logic [15:0] rptr;
        logic [8:0]  nb;
        logic [15:0] walk;
        logic [15:0] lim;
        logic [19:0] timer;
        logic        wen;
        logic        info_sel;
        logic        erased;
        logic [7:0]  tx;
        logic [7:0]  stat;
        logic [7:0]  prot;
        logic        dmem;
    } fsq_core_s;
endpackage : fsq_pkg

// ===== rtl/fsq_link.sv
// Serial slave shifter on the programmer's serial clock
module fsq_link
    import fsq_pkg::*;
(
    // Clock and resets
    input  wire logic       sck,
    input  wire logic       rst,
    input  wire logic       select_low,
    // Serial data
    input  wire logic       mosi,
    output logic            miso,
    // Core side
    input  wire logic [7:0] tx_byte,
    output fsq_rx_s         rx
);
    fsq_link_s link_q;
    fsq_link_s link_d;
    fsq_rx_s   rx_q;
    fsq_rx_s   rx_d;
    logic [7:0] txsr_q;
    logic       frame_rst;

    // Deselect clears the bit position, so a stopped clock is harmless
    assign frame_rst = rst | select_low;

    // Next state of the shifter and the byte toggle
    always_comb
    begin
        link_d = link_q;
        rx_d = rx_q;
        link_d.bitcnt = link_q.bitcnt + 3'h1;
        link_d.sr = {link_q.sr[5:0], mosi};
        if (link_q.bitcnt == 3'h7)
        begin
            rx_d.data = {link_q.sr, mosi};
            rx_d.tgl = ~rx_q.tgl;
        end
    end

    // Bit position, cleared by every frame end
    always_ff @(posedge sck or posedge frame_rst)
    begin
        if (frame_rst)
            link_q <= '0;
        else
            link_q <= link_d;
    end

    // Byte and toggle survive deselect so the core sees one edge per byte
    always_ff @(posedge sck or posedge rst)
    begin
        if (rst)
            rx_q <= '0;
        else
            rx_q <= rx_d;
    end

    // Output byte loads after each completed byte, shifts on falling edges
    always_ff @(negedge sck or posedge frame_rst)
    begin
        if (frame_rst)
            txsr_q <= 8'h00;
        else if (link_q.bitcnt == 3'h0)
            txsr_q <= tx_byte;
        else
            txsr_q <= {txsr_q[6:0], 1'b0};
    end

    assign miso = txsr_q[7];
    assign rx = rx_q;
endmodule : fsq_link

// ===== tb/fsq_programming_mode_pin_model.sv
// Programmer model driving the serial port in whole frames
module fsq_programming_mode_pin_model (
    // Serial port
    output logic      sck,
    output logic      ssn,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       raw;
    logic       en;
    logic [7:0] tx_buf [8];
    logic [7:0] rx_buf [8];

    // Free 64 ns clock, passed on only inside frames
    initial
    begin
        raw = 1'b0;
        en = 1'b0;
        ssn = 1'b1;
        mosi = 1'b0;
        #7;
        forever #32 raw = ~raw;
    end
    assign sck = en & raw;

    // Frame of n bytes, command first, each byte MSB first
    task automatic frame(input int n);
        #200;
        @(negedge raw) ssn = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                @(negedge raw);
                mosi = tx_buf[k][i];
                en = 1'b1;
                @(posedge raw);
                rx_buf[k][i] = miso;
            end
            @(negedge raw);
            en = 1'b0;
            mosi = ~mosi; // Released line shows no stale level
            #560;
        end
        ssn = 1'b1;
    endtask : frame
endmodule : fsq_programming_mode_pin_model

// ===== tb/tb_flash_spi_programming_sequence.sv
// Self-checking bench for the flash programming sequencer
module tb_flash_spi_programming_sequence
    import fsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int ERC = 2000;
    localparam int BYC = 20;

    logic       clk, rst, pin, ssn, sck, mosi, miso;
    logic       nrdy, wen, info, mrb, irb, dmem;
    logic [7:0] prot;
    int         num_errors = 0;
    int         compares = 0;

    fsq_core #(.ERASE_CYC(ERC), .BYTE_CYC(BYC)) DUT (
        .CLK                  (clk),
        .RST                  (rst),
        .PROGRAMMING_MODE_PIN (pin),
        .SERIAL_SELECT_LOW    (ssn),
        .SERIAL_CLOCK         (sck),
        .SERIAL_IN            (mosi),
        .SERIAL_OUT           (miso),
        .NOT_READY            (nrdy),
        .WRITE_ENABLED        (wen),
        .INFO_AREA_SELECT     (info),
        .MAIN_READBACK_BLOCK  (mrb),
        .INFO_READBACK_BLOCK  (irb),
        .DATA_MEMORY_ENABLE   (dmem),
        .PROTECTED_PAGE       (prot)
    );

    fsq_programming_mode_pin_model P (.sck(sck), .ssn(ssn), .mosi(mosi), .miso(miso));

    // Crystal clock, 25 ns
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compares one value
    task automatic chk(input string nm, input logic [7:0] s, e);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // Prints the counts and the verdict
    task automatic summarize;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Sends one frame of up to six bytes
    task automatic send(input int n, input logic [7:0] b0,
        b1 = 8'h00, b2 = 8'h00, b3 = 8'h00, b4 = 8'h00);
        P.tx_buf[0] = b0;
        P.tx_buf[1] = b1;
        P.tx_buf[2] = b2;
        P.tx_buf[3] = b3;
        P.tx_buf[4] = b4;
        P.tx_buf[5] = 8'h00;
        P.frame(n);
    endtask : send

    // Lets a few crystal cycles pass after a frame
    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    // Waits out an operation; times it from deselect when t is nonzero
    task automatic op_time(input string nm, input int t);
        int c;
        c = 0;
        while (nrdy !== 1'b1 && c < 12)
        begin
            @(posedge clk);
            #1 c++;
        end
        chk({nm, " busy"}, 8'(nrdy), 8'h01);
        while (nrdy !== 1'b0 && c < t + ERC)
        begin
            @(posedge clk);
            #1 c++;
        end
        if (t > 0)
            chk({nm, " time"}, 8'(c >= t - 1 && c <= t + 1), 8'h01);
        if (nrdy !== 1'b0)
        begin
            num_errors++;
            summarize();
        end
    endtask : op_time

    // Bulk erase after write enable
    task automatic t_erase_all;
        send(1, 8'h06);
        settle();
        chk("wen set", 8'(wen), 8'h01);
        send(1, 8'h62);
        op_time("erase all", ERC);
        chk("wen after erase", 8'(wen), 8'h00);
        $display("test erase_all done");
    endtask : t_erase_all

    // Info area erase with select and enable set by status write
    task automatic t_info_erase;
        send(2, 8'h01, 8'h0a);
        settle();
        chk("wen", 8'(wen), 8'h01);
        chk("info sel", 8'(info), 8'h01);
        send(2, 8'h52, 8'h00);
        op_time("page erase", ERC);
        chk("main block", 8'(mrb), 8'h00);
        chk("info block", 8'(irb), 8'h00);
        chk("data mem", 8'(dmem), 8'h00);
        chk("prot page", prot, 8'hff);
        // Puts the unique id bytes back after the erase
        send(2, 8'h01, 8'h0a);
        send(5, 8'h02, 8'h00, 8'h0b, 8'h5a, 8'hc3);
        op_time("id restore", 3 * BYC);
        send(6, 8'h03, 8'h00, 8'h0b);
        chk("id byte 0", P.rx_buf[4], 8'h5a);
        chk("id byte 1", P.rx_buf[5], 8'hc3);
        $display("test info_erase done");
    endtask : t_info_erase

    // Main array program, read back, and program without enable
    task automatic t_program;
        send(2, 8'h01, 8'h02);
        send(5, 8'h02, 8'h00, 8'h10, 8'ha5, 8'h3c);
        op_time("program", 3 * BYC);
        send(6, 8'h03, 8'h00, 8'h10);
        chk("read d0", P.rx_buf[4], 8'ha5);
        chk("read d1", P.rx_buf[5], 8'h3c);
        send(4, 8'h02, 8'h00, 8'h20, 8'h00);
        settle();
        chk("no wen programming_mode_pin", 8'(nrdy), 8'h00);
        $display("test program done");
    endtask : t_program

    // Info area fields: protected page and data memory enable
    task automatic t_info_fields;
        send(2, 8'h01, 8'h0a);
        send(4, 8'h02, 8'h00, 8'h20, 8'h05);
        op_time("prot programming_mode_pin", 2 * BYC);
        chk("prot page", prot, 8'h05);
        send(1, 8'h06);
        send(4, 8'h02, 8'h00, 8'h21, 8'h00);
        op_time("dmem programming_mode_pin", 2 * BYC);
        chk("data mem", 8'(dmem), 8'h01);
        $display("test info_fields done");
    endtask : t_info_fields

    // Readback blocks, blocked read and refused program
    task automatic t_readback;
        send(1, 8'h06);
        send(1, 8'h85);
        op_time("main block", BYC);
        chk("main block", 8'(mrb), 8'h01);
        chk("wen cleared", 8'(wen), 8'h00);
        send(1, 8'h06);
        send(1, 8'h84);
        op_time("info block", BYC);
        chk("info block", 8'(irb), 8'h01);
        send(6, 8'h03, 8'h00, 8'h10);
        chk("blocked read", P.rx_buf[4], 8'h00);
        send(1, 8'h06);
        send(4, 8'h02, 8'h00, 8'h10, 8'h00);
        settle();
        chk("blocked programming_mode_pin", 8'(nrdy), 8'h00);
        $display("test readback done");
    endtask : t_readback

    // Mid-run reset; info erase refused while main array protected
    task automatic t_refuse;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("mid rst wen", 8'(wen), 8'h00);
        rst = 1'b0;
        send(2, 8'h01, 8'h0a);
        send(2, 8'h52, 8'h00);
        settle();
        chk("refused erase", 8'(nrdy), 8'h00);
        chk("info kept", 8'(irb), 8'h01);
        $display("test refuse done");
    endtask : t_refuse

    // Bulk erase with status polling; info area must survive
    task automatic t_busy;
        send(1, 8'h06);
        send(1, 8'h62);
        settle();
        chk("busy", 8'(nrdy), 8'h01);
        send(3, 8'h05);
        chk("status busy", P.rx_buf[2], 8'h6b);
        send(2, 8'h01, 8'h00);
        settle();
        chk("ignored wsr", 8'(info), 8'h01);
        op_time("erase idle", 0);
        chk("info block kept", 8'(irb), 8'h01);
        chk("main block kept", 8'(mrb), 8'h01);
        chk("prot kept", prot, 8'h05);
        chk("dmem kept", 8'(dmem), 8'h01);
        $display("test busy done");
    endtask : t_busy

    // Main sequence
    initial
    begin
        rst = 1'b1;
        pin = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk("rst nrdy", 8'(nrdy), 8'h00);
        chk("rst wen", 8'(wen), 8'h00);
        chk("rst prot", prot, 8'h00);
        rst = 1'b0;
        @(posedge clk);
        #1 pin = 1'b1;
        repeat (80000) @(posedge clk);
        t_erase_all();
        t_info_erase();
        t_program();
        t_info_fields();
        t_readback();
        t_refuse();
        t_busy();
        summarize();
    end
endmodule : tb_flash_spi_programming_sequence
